// ==== sipo_shifter.sv ====
// Purpose: Eight-stage serial-in, parallel-out shift register with gated serial entry.
// Assumes: Shift clock, serial inputs and clear are pins sampled by the 10 MHz system clock.
// Notes:   Every shifted word is also offered to a snapshot FIFO; a full FIFO drops the snapshot.
`timescale 1ns/1ps
module sipo_shifter (
	input  wire logic       clk,           // System clock, 10 MHz.
	input  wire logic       sys_rst,       // Asynchronous reset, active high.
	input  wire logic       shift_clk_pin, // Shift clock pin, rising edge shifts.
	input  wire logic       serial_a,      // First serial data pin.
	input  wire logic       serial_b,      // Second serial data pin.
	input  wire logic       async_zero_n,  // Clear pin, active low.
	output wire logic [7:0] stage_q,       // Parallel stage outputs, bit 0 is first stage.
	output wire logic       snap_room,     // Snapshot FIFO can take a word.
	output wire logic       snap_drop,     // Pulse: a snapshot was lost to a full FIFO.
	output wire logic       snap_valid,    // Snapshot word available.
	input  wire logic       snap_ready,    // Consumer takes the snapshot word.
	output wire logic [7:0] snap_data      // Snapshot word.
);

	localparam int N = shifter_pkg::STAGES;

	logic [N-1:0]                    stage_reg;
	logic [shifter_pkg::SYNC_DEPTH:0] clk_sync_reg;
	logic [1:0]                      a_sync_reg;
	logic [1:0]                      b_sync_reg;
	logic [1:0]                      zero_sync_reg;
	logic                            drop_reg;
	wire logic                       clk_now;
	wire logic                       clk_old;
	wire logic                       a_now;
	wire logic                       b_now;
	wire logic                       zero_done;
	wire logic                       fall;
	wire logic                       rise;
	wire logic                       shift_ok;
	wire logic                       entry_bit;
	wire logic [N-1:0]               stage_next;

	// ****************************************
	// Pin synchronisers
	// ****************************************

	// Shift clock and serial data pass two flops; a third clock flop feeds the edge detector.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			clk_sync_reg <= '0;
			a_sync_reg   <= 2'h0;
			b_sync_reg   <= 2'h0;
		end else begin
			clk_sync_reg <= {clk_sync_reg[shifter_pkg::SYNC_DEPTH-1:0], shift_clk_pin};
			a_sync_reg   <= {a_sync_reg[0], serial_a};
			b_sync_reg   <= {b_sync_reg[0], serial_b};
		end
	end

	// Clear asserts at once and releases through two flops, so no shift follows a release too soon.
	always_ff @(posedge clk or posedge sys_rst or negedge async_zero_n) begin
		if (sys_rst) begin
			zero_sync_reg <= 2'h0;
		end else if (!async_zero_n) begin
			zero_sync_reg <= 2'h0;
		end else begin
			zero_sync_reg <= {zero_sync_reg[0], 1'b1};
		end
	end

	// ****************************************
	// Synchronised views
	// ****************************************

	// Only the second and third flops are read past this point; the first may still be settling.
	assign clk_now   = clk_sync_reg[1];
	assign clk_old   = clk_sync_reg[shifter_pkg::SYNC_DEPTH];
	assign a_now     = a_sync_reg[1];
	assign b_now     = b_sync_reg[1];
	assign zero_done = zero_sync_reg[1];

	// ****************************************
	// Shift path
	// ****************************************

	// Edge and entry decode; only the rising edge counts and data are read only at it.
	assign rise       = clk_now && !clk_old;
	assign fall       = clk_old && !clk_now;
	assign shift_ok   = rise && zero_done;
	assign entry_bit  = a_now & b_now;
	assign stage_next = shift_ok ? {stage_reg[N-2:0], entry_bit} : stage_reg;

	// Stage register; the clear pin zeroes it without the clock.
	always_ff @(posedge clk or posedge sys_rst or negedge async_zero_n) begin
		if (sys_rst) begin
			stage_reg <= shifter_pkg::STAGE_RESET;
		end else if (!async_zero_n) begin
			stage_reg <= shifter_pkg::STAGE_RESET;
		end else begin
			stage_reg <= stage_next;
		end
	end

	assign stage_q = stage_reg;

	// ****************************************
	// Snapshot buffering
	// ****************************************

	// Flags a shift whose snapshot found no room.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			drop_reg <= 1'b0;
		end else begin
			drop_reg <= shift_ok && !snap_room;
		end
	end

	assign snap_drop = drop_reg;

	snap_fifo #(
		.WIDTH (N),
		.DEPTH (shifter_pkg::SNAP_DEPTH)
	) u_fifo (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (shift_ok),
		.in_ready  (snap_room),
		.in_data   (stage_next),
		.out_valid (snap_valid),
		.out_ready (snap_ready),
		.out_data  (snap_data)
	);

	// ****************************************
	// Checks
	// ****************************************

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// An accepted rising edge of the shift clock.
	sequence shift_ev;
		rise && zero_done;
	endsequence

	// Clear has stood high on two edges in a row.
	sequence clear_free;
		async_zero_n [*2];
	endsequence

	// A falling edge of the shift clock while clear is high.
	sequence fall_ev;
		fall && async_zero_n;
	endsequence

	// Clear is high again, but its release is still inside the two-flop retimer.
	sequence release_pending;
		async_zero_n && !zero_done;
	endsequence

	// The shift clock was low and has just been seen high, with the third flop still low.
	sequence pin_rise;
		!clk_now ##1 (clk_now && !clk_old);
	endsequence

	// Every stage but the first takes the old value of its neighbour.
	shift_move_a: assert property (shift_ev ##0 async_zero_n |=>
		!async_zero_n || stage_reg[N-1:1] == $past(stage_reg[N-2:0]))
		else $error("Stages did not shift by one on a rising edge.");

	// The entering bit is the AND of both synchronised serial inputs.
	entry_and_a: assert property (shift_ev ##0 async_zero_n |=>
		!async_zero_n || stage_reg[0] == $past(a_now & b_now))
		else $error("First stage did not take the AND of the serial inputs.");

	// A low on either serial input blocks new data.
	entry_low_a: assert property (shift_ev ##0 !b_now |=> stage_reg[0] == 1'b0)
		else $error("First stage loaded high with a serial input low.");
	entry_gate_a: assert property (shift_ev ##0 !a_now |=> stage_reg[0] == 1'b0)
		else $error("First stage loaded high with the first serial input low.");

	// With the first input high, the second alone decides the entering bit.
	entry_pass_a: assert property (shift_ev ##0 (a_now && async_zero_n) |=>
		!async_zero_n || stage_reg[0] == $past(b_now))
		else $error("First stage did not follow the other serial input.");

	// All eight stages present the new word together after a shift.
	word_whole_a: assert property (shift_ev ##0 async_zero_n |=>
		!async_zero_n || stage_q == {$past(stage_q[N-2:0]), $past(entry_bit)})
		else $error("Parallel outputs did not show the shifted word.");

	// A low clear holds every stage and output low.
	clear_zero_a: assert property (!async_zero_n |-> stage_reg == '0 && stage_q == '0)
		else $error("Stages not low while clear is low.");

	// Without an edge and with clear high, nothing moves.
	hold_level_a: assert property (clear_free ##0 !$past(rise) |-> $stable(stage_reg))
		else $error("Stages changed without a rising edge.");

	// Any change traces back to a rising edge, never a falling one.
	edge_only_a: assert property (clear_free ##0 !$stable(stage_reg) |-> $past(rise) && !$past(clk_old))
		else $error("Stages changed on something other than a rising edge.");
	fall_idle_a: assert property (fall_ev |=> !async_zero_n || $stable(stage_reg))
		else $error("Stages changed on a falling edge.");

	// One pin edge gives exactly one shift pulse.
	rise_single_a: assert property (pin_rise |=> !rise)
		else $error("One pin edge produced more than one shift.");

	// While the clear release is retimed, stages stay low and edges are ignored.
	release_low_a: assert property (!zero_done ##1 !zero_done |-> stage_reg == '0)
		else $error("Stages not low before the first edge after clear.");
	pending_edge_a: assert property (release_pending ##0 rise |=> stage_reg == '0)
		else $error("An edge shifted while the clear release was pending.");

	// Serial inputs enter only at an accepted edge.
	sample_edge_a: assert property (!shift_ev ##0 async_zero_n |=>
		!async_zero_n || stage_reg[0] == $past(stage_reg[0]))
		else $error("Serial inputs entered without a rising edge.");

	// A shift that finds the snapshot buffer full is flagged for one cycle.
	drop_pulse_a: assert property (shift_ev ##0 !snap_room |=> snap_drop)
		else $error("Lost snapshot was not flagged.");
	drop_cause_a: assert property (snap_drop |-> $past(shift_ok) && !$past(snap_room))
		else $error("Snapshot loss flagged without a lost snapshot.");

endmodule

// ==== shifter_pkg.sv ====
// Purpose: Shared constants for the serial-in, parallel-out shifter.
// Assumes: One system clock of 10 MHz; shift clock, serial data and clear arrive as pins.
// Notes:   Shared by the shifter and its checks; the behaviour list follows.
// Operation
// - Eight stages are shown together on eight parallel outputs, first to eighth.
// - The bit entering the first stage is the AND of the two serial data inputs.
// - A low on either serial input at a rising shift edge loads a low into the first stage.
// - With one serial input high, the other alone decides the bit loaded at the next rising edge.
// - Stages change only on the rising shift edge, never on the falling one.
// - Serial inputs are sampled only at the rising shift edge and ignored otherwise.
// - While the clear input is low, all stages and outputs are forced low at once.
// - With clear inactive and no rising edge, every output holds its level.
// - Each accepted rising edge shifts by one: stages two to eight take the old value of the stage before.
package shifter_pkg;

	// ****************************************
	// Sizes and timing
	// ****************************************
	localparam int STAGES         = 8;   // Parallel stage count.
	localparam int SYNC_DEPTH     = 2;   // Synchroniser flip-flops per pin input; the shift clock has one more.
	localparam int SNAP_DEPTH     = 8;   // Snapshot FIFO depth in words.
	localparam int CLK_PERIOD_NS  = 100; // System clock period.
	localparam logic [7:0] STAGE_RESET = 8'h00; // Cleared stage value.

endpackage

// ==== snap_fifo.sv ====
// Purpose: Small FIFO with valid and ready on both sides and a registered read word.
// Assumes: DEPTH is a power of two of at least two.
// Notes:   Holds up to DEPTH words in storage plus one in the output register.
`timescale 1ns/1ps
module snap_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,       // System clock.
	input  wire logic             sys_rst,   // Asynchronous reset, active high.
	input  wire logic             in_valid,  // Word offered.
	output wire logic             in_ready,  // Room for a word.
	input  wire logic [WIDTH-1:0] in_data,   // Offered word.
	output wire logic             out_valid, // Head word present.
	input  wire logic             out_ready, // Consumer takes head.
	output wire logic [WIDTH-1:0] out_data   // Head word, registered.
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [WIDTH-1:0] head_reg;
	logic             head_valid_reg;
	wire logic        push;
	wire logic        load;

	// Handshake decode: push into storage, load storage head into output register.
	assign in_ready  = count_reg < (AW+1)'(DEPTH);
	assign push      = in_valid && in_ready;
	assign load      = (count_reg != '0) && (!head_valid_reg || out_ready);
	assign out_valid = head_valid_reg;
	assign out_data  = head_reg;

	// Storage write.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers, count and output register.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_reg     <= '0;
			rd_ptr_reg     <= '0;
			count_reg      <= '0;
			head_reg       <= '0;
			head_valid_reg <= 1'b0;
		end else begin
			wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
			rd_ptr_reg <= load ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
			count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(load);
			if (load) begin
				head_reg       <= mem_reg[rd_ptr_reg];
				head_valid_reg <= 1'b1;
			end else if (out_ready) begin
				head_valid_reg <= 1'b0;
			end
		end
	end

endmodule

// ==== upstream_drv.sv ====
// Purpose: Upstream logic model that drives the shifter's serial pins and shift clock.
// Assumes: One frame per go pulse; data is set 3 clk before the rising pin edge.
// Notes:   The shift clock stands low between frames.
`timescale 1ns/1ps
module upstream_drv (
	input  wire logic clk,           // System clock.
	input  wire logic sys_rst,       // Reset, active high.
	input  wire logic go,            // Start one frame.
	input  wire logic a_in,          // Bit for the first serial pin.
	input  wire logic b_in,          // Bit for the second serial pin.
	output wire logic busy,          // Frame in progress.
	output wire logic shift_clk_pin, // Shift clock pin.
	output logic      serial_a,      // First serial pin.
	output logic      serial_b       // Second serial pin.
);
	logic [3:0] cnt_reg;

	// Pin high for 3 clk, after the data has been steady for 3 clk.
	assign busy = cnt_reg != 4'h0;
	assign shift_clk_pin = (cnt_reg >= 4'h4) && (cnt_reg < 4'h7);

	// Data is held until the next frame, well past the hold time.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_reg <= 4'h0;
			serial_a <= 1'b0;
			serial_b <= 1'b0;
		end else if (go && !busy) begin
			cnt_reg <= 4'h1;
			serial_a <= a_in;
			serial_b <= b_in;
		end else if (busy) begin
			cnt_reg <= (cnt_reg == 4'ha) ? 4'h0 : cnt_reg + 4'h1;
		end
	end
endmodule

// ==== tb.sv ====
// Purpose: Self-checking bench for the shifter and its snapshot FIFO.
// Assumes: 10 MHz clock; frames come from the upstream model.
// Notes:   Rows hold {a, b, expected stages}.
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0, sys_rst = 1'b1, go = 1'b0, a_r = 1'b0, b_r = 1'b0;
	logic async_zero_n = 1'b1, snap_ready = 1'b0;
	wire logic busy, shift_clk_pin, serial_a, serial_b, snap_room, snap_drop, snap_valid;
	wire logic [7:0] stage_q, snap_data;
	int n_fail = 0, samples_checked = 0, n_drop = 0, i, k;
	logic [9:0] rows [10] = '{10'h301, 10'h202, 10'h104, 10'h309, 10'h012,
		10'h325, 10'h34b, 10'h296, 10'h32d, 10'h35b};

	always #(shifter_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
	always @(posedge clk) if (snap_drop === 1'b1) n_drop++;

	upstream_drv u_drv (.clk(clk), .sys_rst(sys_rst), .go(go), .a_in(a_r), .b_in(b_r), .busy(busy),
		.shift_clk_pin(shift_clk_pin), .serial_a(serial_a), .serial_b(serial_b));
	sipo_shifter u_dut (.clk(clk), .sys_rst(sys_rst), .shift_clk_pin(shift_clk_pin), .serial_a(serial_a),
		.serial_b(serial_b), .async_zero_n(async_zero_n), .stage_q(stage_q), .snap_room(snap_room),
		.snap_drop(snap_drop), .snap_valid(snap_valid), .snap_ready(snap_ready), .snap_data(snap_data));

	// Compare one value and count the outcome.
	task check(input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want) begin
			n_fail++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	// Send one frame and wait for it to settle.
	task shift(input logic a, input logic b);
		@(posedge clk) go <= 1'b1;
		a_r <= a;
		b_r <= b;
		@(posedge clk) go <= 1'b0;
		#1 k = 0;
		while (busy !== 1'b0 && k < 20) begin
			@(posedge clk);
			#1 k++;
		end
		if (k >= 20) n_fail++;
	endtask

	task print_verdict;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		#200000 n_fail++;
		print_verdict();
	end

	// Row loop, then FIFO full and drain, then clear handling.
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		#1 check(stage_q, 8'h00);
		check({snap_valid, snap_room}, 8'h01);
		repeat (3) @(posedge clk);
		for (i = 0; i < 10; i++) begin
			shift(rows[i][9], rows[i][8]);
			check(stage_q, rows[i][7:0]);
		end
		check(snap_room, 8'h00);
		check(8'(n_drop), 8'h01);
		repeat (20) @(posedge clk);
		#1 check(stage_q, 8'h5b);
		for (i = 0; i < 9; i++) begin
			k = 0;
			while (snap_valid !== 1'b1 && k < 10) begin
				@(posedge clk);
				#1 k++;
			end
			check(snap_data, rows[i][7:0]);
			@(posedge clk) snap_ready <= 1'b1;
			@(posedge clk) snap_ready <= 1'b0;
			@(posedge clk);
			#1;
		end
		repeat (3) @(posedge clk);
		#1 check(snap_valid, 8'h00);
		@(posedge clk) async_zero_n <= 1'b0;
		#1 check(stage_q, 8'h00);
		shift(1'b1, 1'b1);
		check(stage_q, 8'h00);
		fork
			shift(1'b1, 1'b1);
			begin
				repeat (6) @(posedge clk);
				async_zero_n <= 1'b1;
			end
		join
		check(stage_q, 8'h00);
		shift(1'b1, 1'b1);
		check(stage_q, 8'h01);
		print_verdict();
	end
endmodule
